// *** core/cpc_post_charge_regs.sv ***
// Purpose: post-charge configuration and live monitor registers
// Assumes: register port decoded from the serial control port upstream
// Notes:   monitor is sampled each cycle so a read shows live state
//
// What this block does
// - policy bits 7:6 gate battery absent detection
// - charge done: load input every two seconds
// - bit 3 enables background charging
// - bits 2:0 hold background termination current
// - monitor 10H bit 7: current above termination
// - monitor bit 6: battery below input
// - monitor bit 5: trickle linear charger active
// - bit 4 hot die; limit current
// - bit 3 zero when charge loop controls
// - bit 2 zero when input loop controls
// - bit 1 one when input validated
// - bit 0: float loop alone in control
// - config at address 07, resets to 01H
`timescale 1ns/100ps
module cpc_post_charge_regs #(
  parameter int TICK_CYCLES = cpc_pkg::CPC_TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire cpc_pkg::cpc_analog_t analog_i,
  input wire cpc_pkg::cpc_state_t state_i,
  output logic absent_detect_req_o,
  output logic input_load_o,
  output logic background_charge_enable_o,
  output logic [2:0] background_term_current_o,
  output logic thermal_limit_o
);
  import cpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] post_charge_config_reg;
  logic [7:0] charger_monitor_flags_reg;
  logic [7:0] charger_monitor_flags_next;
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
  logic ms_tick_reg;
  logic detect_allowed;
  logic [1:0] policy;

  assign policy = post_charge_config_reg[CPC_POLICY_HI:CPC_POLICY_LO];

  ////////////////////////////////////////////////////////////////////////////
  // configuration register, host writable
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      post_charge_config_reg <= CPC_POST_CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == CPC_ADDR_POST_CFG) begin
      post_charge_config_reg <= reg_wdata_i;
    end
  end

  // monitor image from live comparators; writes never reach it
  always_comb begin
    charger_monitor_flags_next = '0;
    charger_monitor_flags_next[CPC_MON_TERM_BIT] =
      analog_i.term_current_compare;
    charger_monitor_flags_next[CPC_MON_VBELOW_BIT] =
      analog_i.battery_below_input_compare;
    charger_monitor_flags_next[CPC_MON_TRICKLE_BIT] =
      analog_i.trickle_linear_active;
    charger_monitor_flags_next[CPC_MON_HOT_BIT] = analog_i.die_hot;
    charger_monitor_flags_next[CPC_MON_CHGLOOP_BIT] =
      !analog_i.charge_loop_active;
    charger_monitor_flags_next[CPC_MON_INLOOP_BIT] =
      !analog_i.input_loop_active;
    charger_monitor_flags_next[CPC_MON_VALID_BIT] =
      analog_i.input_valid;
    charger_monitor_flags_next[CPC_MON_VLOOP_BIT] =
      analog_i.float_voltage_regulation &&
      analog_i.others_released;
  end

  // sampled every cycle so reads are at most one cycle stale
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      charger_monitor_flags_reg <= '0;
    end else begin
      charger_monitor_flags_reg <= charger_monitor_flags_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses read zero
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          CPC_ADDR_POST_CFG: reg_rdata_o <= post_charge_config_reg;
          CPC_ADDR_MONITOR: reg_rdata_o <= charger_monitor_flags_reg;
          default: reg_rdata_o <= CPC_READ_UNMAPPED;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // absent detection policy when the thermistor goes out of range
  always_comb begin
    unique case (policy)
      CPC_POL_ALWAYS: detect_allowed = 1'b1;
      CPC_POL_NO_NORMAL: detect_allowed = state_i.charge_done;
      CPC_POL_NO_PWM_DONE: detect_allowed = !state_i.pwm_after_done;
      CPC_POL_NO_DONE: detect_allowed = !state_i.charge_done;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      absent_detect_req_o <= 1'b0;
    end else begin
      absent_detect_req_o <= state_i.thermistor_out_of_range &&
                             detect_allowed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // background charge controls as registered copies of the fields, plus the registered hot-die limit
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      background_charge_enable_o <= 1'b0;
      background_term_current_o <= '0;
      thermal_limit_o <= 1'b0;
    end else begin
      background_charge_enable_o <=
        post_charge_config_reg[CPC_BG_EN_BIT];
      background_term_current_o <=
        post_charge_config_reg[CPC_TERM_HI:CPC_TERM_LO];
      thermal_limit_o <= analog_i.die_hot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond enable; one clock only, slow rates are enables
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tick_cnt_reg <= '0;
      ms_tick_reg <= 1'b0;
    end else if (tick_cnt_reg ==
                 ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      ms_tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      ms_tick_reg <= 1'b0;
    end
  end

  // pulser runs only in the charge-done state
  cpc_load_pulser u_pulser (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .ms_tick_i(ms_tick_reg),
    .armed_i(state_i.charge_done),
    .select_i(post_charge_config_reg[CPC_LOAD_HI:CPC_LOAD_LO]),
    .load_o(input_load_o)
  );

endmodule : cpc_post_charge_regs

// *** core/cpc_pkg.sv ***
// Purpose: shared constants and types for the post-charge register bank
// Assumes: 125 MHz reference clock, 8-bit register port
// Notes:   every offset, field position, reset value and count lives here
package cpc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] CPC_ADDR_POST_CFG = 8'h07;
  localparam logic [7:0] CPC_ADDR_MONITOR = 8'h10;
  localparam logic [7:0] CPC_POST_CFG_RESET = 8'h01;
  localparam logic [7:0] CPC_READ_UNMAPPED = 8'h00;

  // post-charge configuration field positions
  localparam int CPC_POLICY_HI = 7;
  localparam int CPC_POLICY_LO = 6;
  localparam int CPC_LOAD_HI = 5;
  localparam int CPC_LOAD_LO = 4;
  localparam int CPC_BG_EN_BIT = 3;
  localparam int CPC_TERM_HI = 2;
  localparam int CPC_TERM_LO = 0;

  // monitor field positions
  localparam int CPC_MON_TERM_BIT = 7;
  localparam int CPC_MON_VBELOW_BIT = 6;
  localparam int CPC_MON_TRICKLE_BIT = 5;
  localparam int CPC_MON_HOT_BIT = 4;
  localparam int CPC_MON_CHGLOOP_BIT = 3;
  localparam int CPC_MON_INLOOP_BIT = 2;
  localparam int CPC_MON_VALID_BIT = 1;
  localparam int CPC_MON_VLOOP_BIT = 0;

  // absent detection policy codes
  localparam logic [1:0] CPC_POL_ALWAYS = 2'h0;
  localparam logic [1:0] CPC_POL_NO_NORMAL = 2'h1;
  localparam logic [1:0] CPC_POL_NO_PWM_DONE = 2'h2;
  localparam logic [1:0] CPC_POL_NO_DONE = 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CPC_CLK_PERIOD_NS = 8;
  localparam int CPC_TICK_NS = 1000000;          // one millisecond
  localparam int CPC_TICK_CYCLES = CPC_TICK_NS / CPC_CLK_PERIOD_NS;
  localparam int CPC_LOAD_PERIOD_MS = 2000;      // two seconds
  localparam int CPC_LOAD_SHORT_MS = 4;
  localparam int CPC_LOAD_MID_MS = 131;
  localparam int CPC_LOAD_LONG_MS = 135;
  localparam int CPC_MS_W = 11;

  //////////////////////////////////////////////////////////////////////////
  // live analog comparator and loop states, already in the clock domain
  typedef struct packed {
    logic term_current_compare;        // charge current above term ref
    logic battery_below_input_compare; // battery below input supply
    logic trickle_linear_active;       // 30 mA linear charger on
    logic die_hot;                     // die above 120 C
    logic charge_loop_active;          // charge current loop in control
    logic input_loop_active;           // input current loop in control
    logic input_valid;                 // input supply validated
    logic float_voltage_regulation;    // float voltage loop in control
    logic others_released;             // every other limiting loop off
  } cpc_analog_t;

  // charger state seen by the policy logic
  typedef struct packed {
    logic thermistor_out_of_range;
    logic charge_done;
    logic pwm_after_done;
  } cpc_state_t;

endpackage : cpc_pkg

// *** core/cpc_load_pulser.sv ***
// Purpose: periodic input load pulse while charge is done
// Assumes: ms_tick_i is a one-cycle pulse every millisecond
// Notes:   the window restarts whenever the pulser is not armed
`timescale 1ns/100ps
module cpc_load_pulser (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ms_tick_i,
  input wire logic armed_i,
  input wire logic [1:0] select_i,
  output logic load_o
);
  import cpc_pkg::*;

  logic [CPC_MS_W-1:0] ms_reg;
  logic [CPC_MS_W-1:0] dur;

  // duration per code; zero means no loading
  always_comb begin
    unique case (select_i)
      2'h0: dur = '0;
      2'h1: dur = CPC_MS_W'(CPC_LOAD_SHORT_MS);
      2'h2: dur = CPC_MS_W'(CPC_LOAD_MID_MS);
      2'h3: dur = CPC_MS_W'(CPC_LOAD_LONG_MS);
    endcase
  end

  // millisecond position inside the two-second period
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !armed_i) begin
      ms_reg <= '0;
    end else if (ms_tick_i) begin
      if (ms_reg == CPC_MS_W'(CPC_LOAD_PERIOD_MS - 1)) begin
        ms_reg <= '0;
      end else begin
        ms_reg <= ms_reg + 1'b1;
      end
    end
  end

  // load at the start of each period for the chosen time
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      load_o <= 1'b0;
    end else begin
      load_o <= armed_i && (ms_reg < dur);
    end
  end

endmodule : cpc_load_pulser

// *** tb/cpc_host_model.sv ***
// Purpose: host side of the register port
// Assumes: strobes change at falling edges
// Notes:   idle address and data show inverted values
`timescale 1ns/100ps
module cpc_host_model (
  input wire logic ref_clk_i,
  output logic [7:0] addr_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00,
  output logic rd_o = 1'b0,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  // one strobe cycle; stale values are not left on the lines
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge ref_clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr
  // answer stands in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge ref_clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rvalid_i ? rdata_i : 8'hxx;
  endtask : rd
endmodule : cpc_host_model

// *** tb/cpc_regs_sva.sv ***
// Purpose: port checks for the post-charge register bank
// Assumes: config shadow rebuilt from the write strobe
// Notes:   reset edge guarded where past values are used, except in chk_cfg_read
`timescale 1ns/100ps
module cpc_regs_sva #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire cpc_pkg::cpc_analog_t analog_i,
  input wire cpc_pkg::cpc_state_t state_i,
  input wire logic absent_detect_req_o,
  input wire logic input_load_o,
  input wire logic background_charge_enable_o,
  input wire logic [2:0] background_term_current_o,
  input wire logic thermal_limit_o
);
  import cpc_pkg::*;
  logic [7:0] cfg_reg;
  logic [7:0] mon;
  logic ok;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // shadow of the config byte, writes elsewhere ignored
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) cfg_reg <= CPC_POST_CFG_RESET;
    else if (reg_wr_i && reg_addr_i == CPC_ADDR_POST_CFG)
      cfg_reg <= reg_wdata_i;
  end
  // expected monitor byte and policy gate
  assign mon = {analog_i[8:5], ~analog_i[4:3], analog_i[2], &analog_i[1:0]};
  always_comb begin
    case (cfg_reg[7:6])
      CPC_POL_ALWAYS: ok = 1'b1;
      CPC_POL_NO_NORMAL: ok = state_i.charge_done;
      CPC_POL_NO_PWM_DONE: ok = !state_i.pwm_after_done;
      default: ok = !state_i.charge_done;
    endcase
  end
  chk_cfg_read: assert property (reg_rd_i && reg_addr_i == CPC_ADDR_POST_CFG
    |=> reg_rvalid_o && reg_rdata_o == $past(cfg_reg)) else $error("cfg read");
  chk_monitor_live: assert property (reg_rd_i && reg_addr_i == CPC_ADDR_MONITOR
    && !$past(srst_i) |=> reg_rdata_o == $past(mon, 2)) else $error("monitor");
  chk_unmapped_zero: assert property (reg_rd_i
    && reg_addr_i != CPC_ADDR_POST_CFG && reg_addr_i != CPC_ADDR_MONITOR
    |=> reg_rdata_o == CPC_READ_UNMAPPED) else $error("unmapped");
  chk_policy_gate: assert property (!$past(srst_i) |-> absent_detect_req_o
    == $past(state_i.thermistor_out_of_range && ok)) else $error("policy");
  chk_load_idle: assert property (!state_i.charge_done
    |=> !input_load_o) else $error("load idle");
  chk_bg_enable: assert property (!$past(srst_i) |->
    background_charge_enable_o == $past(cfg_reg[3])) else $error("enable");
  chk_bg_term: assert property (!$past(srst_i) |->
    background_term_current_o == $past(cfg_reg[2:0])) else $error("term");
  chk_hot_limit: assert property (!$past(srst_i) |->
    thermal_limit_o == $past(analog_i.die_hot)) else $error("hot");
endmodule : cpc_regs_sva
bind cpc_post_charge_regs cpc_regs_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);

// *** tb/testbench.sv ***
// Purpose: register bank bench
// Assumes: TICK_CYCLES of 4 keeps the load window short
// Notes:   inputs move at falling edges only
`timescale 1ns/100ps
module testbench;
  import cpc_pkg::*;
  localparam int T = 4;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, absent_detect_req_o, e;
  logic input_load_o, background_charge_enable_o, thermal_limit_o;
  logic [2:0] background_term_current_o;
  cpc_analog_t analog_i = '0;
  cpc_state_t state_i = '0;
  logic [8:0] pat [4] = '{9'h1ff, 9'h000, 9'h155, 9'h0aa};
  logic [7:0] cfg [2] = '{8'h8f, 8'h70};
  int ms [4] = '{0, 4, 131, 135};
  int failures = 0;
  int compares = 0;
  int n;
  always #4 ref_clk_i = ~ref_clk_i;
  cpc_post_charge_regs #(.TICK_CYCLES(T)) dut (.*);
  cpc_host_model host (.ref_clk_i(ref_clk_i), .addr_o(reg_addr_i),
    .wr_o(reg_wr_i), .wdata_o(reg_wdata_i), .rd_o(reg_rd_i),
    .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o));
  ////////////////////////////////////////
  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
    compares++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] x, input string s);
    logic [7:0] v;
    host.rd(a, v);
    chk(s, x, v);
  endtask : rc
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // hang guard, well past the load windows
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    failures++;
    close_out();
  end
  initial begin
    repeat (16) @(negedge ref_clk_i);
    srst_i = 1'b0;
    rc(CPC_ADDR_POST_CFG, 8'h01, "cfg reset");
    chk("term out", 8'h01, {5'h00, background_term_current_o});
    foreach (cfg[i]) begin
      host.wr(CPC_ADDR_POST_CFG, cfg[i]);
      rc(CPC_ADDR_POST_CFG, cfg[i], "cfg rw");
      chk("enable", {7'h00, cfg[i][3]}, {7'h00, background_charge_enable_o});
      chk("term", {5'h00, cfg[i][2:0]}, {5'h00, background_term_current_o});
    end
    // writes to the monitor and to holes must leave config alone
    host.wr(CPC_ADDR_MONITOR, 8'hff);
    host.wr(8'h08, 8'h5a);
    rc(CPC_ADDR_POST_CFG, 8'h70, "cfg kept");
    rc(8'h08, 8'h00, "unmapped");
    foreach (pat[i]) begin
      analog_i = pat[i];
      rc(CPC_ADDR_MONITOR, {pat[i][8:5], ~pat[i][4:3], pat[i][2], &pat[i][1:0]}, "monitor");
      chk("hot", {7'h00, pat[i][5]}, {7'h00, thermal_limit_o});
    end
    // every policy against every charger state
    for (int p = 0; p < 4; p++) begin
      host.wr(CPC_ADDR_POST_CFG, {p[1:0], 6'h01});
      for (int s = 0; s < 8; s++) begin
        state_i = s[2:0];
        repeat (2) @(negedge ref_clk_i);
        e = s[2] && (p == 0 || (p == 1 && s[1]) || (p == 2 && !s[0]) || (p == 3 && !s[1]));
        chk("absent", {7'h00, e}, {7'h00, absent_detect_req_o});
      end
    end
    // one load window per code; tick phase blurs the length by a tick
    for (int c = 0; c < 4; c++) begin
      state_i = '0;
      host.wr(CPC_ADDR_POST_CFG, {2'h0, c[1:0], 4'h0});
      state_i.charge_done = 1'b1;
      n = 0;
      repeat (1999 * T) begin
        @(negedge ref_clk_i);
        n += input_load_o;
      end
      chk("load", 8'h01, {7'h00, n <= ms[c] * T && n + 2 * T > ms[c] * T});
    end
    close_out();
  end
endmodule : testbench
